// file: rtc_core.sv
// Register file, password gates and BCD time and calendar counters.
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/100ps
// How it works
// - Integer code 0..15 stands for 32761..32776 Hz measured oscillator rate.
// - Fraction field is plain binary, used directly in tick scaling.
// - Time register holds hour, minute, second BCD digits at fixed bit fields.
// - Calendar register holds year, month, day BCD digits at fixed bit fields.
// - Written digits are stored unchecked; software must write valid BCD.
// - Counters, tick and settings hold in reset until the initiation key is written; the bus port still acks.
// - Register access opens on password, closes on timeout or other value.
// - In twelve-hour scale PM hours read with twenty added, AM12 reads 12.
// - Year digits count 00 to 99 meaning 2000 to 2099, then wrap.
module rtc_core
  import rtc_pkg::*;
#(
  parameter int unsigned clk_hz = rtc_clk_hz,
  parameter int unsigned access_hold_cycles = rtc_access_hold_s * clk_hz
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic second_tick
);
  ////////////////////////////////////////////////////////////////////////
  logic active;
  logic access_ok;
  logic [31:0] hold;
  logic [31:0] comp;
  logic [31:0] tod;
  logic [31:0] cal;
  logic scale24;
  logic tick;
  rtc_bus_t bus_st;
  wire req = wb_cyc_i && wb_stb_i && (bus_st == rtc_idle);
  wire wr = req && wb_we_i && (wb_sel_i == 4'hF);
  wire wr_init = wr && (wb_adr_i == rtc_addr_init);
  wire wr_acc = wr && (wb_adr_i == rtc_addr_access);
  wire gated = active && access_ok;
  wire wr_comp = wr && gated && (wb_adr_i == rtc_addr_comp);
  wire wr_time = wr && gated && (wb_adr_i == rtc_addr_time);
  wire wr_cal = wr && gated && (wb_adr_i == rtc_addr_cal);
  wire wr_scale = wr && gated && (wb_adr_i == rtc_addr_scale);
  ////////////////////////////////////////////////////////////////////////
  // Bus handshake: ack one cycle after request, then one idle cycle.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      bus_st <= rtc_idle;
      wb_ack_o <= 1'b0;
    end
    else
    begin
      unique case (bus_st)
        rtc_idle: bus_st <= req ? rtc_ack : rtc_idle;
        rtc_ack: bus_st <= rtc_done;
        rtc_done: bus_st <= rtc_idle;
        default: bus_st <= rtc_idle;
      endcase
      wb_ack_o <= req;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Initiation latch and access window.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      active <= 1'b0;
    else if (wr_init && wb_dat_i == rtc_init_key)
      active <= 1'b1;
  end
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      access_ok <= 1'b0;
      hold <= 32'h00000000;
    end
    else if (wr_acc && active)
    begin
      access_ok <= (wb_dat_i[15:0] == rtc_access_key);
      hold <= 32'(access_hold_cycles);
    end
    else if (hold != 32'h00000000)
      hold <= hold - 32'h00000001;
    else
      access_ok <= 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  rtc_tick #(.clk_hz(clk_hz)) u_tick
  (
    .clk(clk),
    .nrst(nrst),
    .run(active),
    .comp_int(comp[11:8]),
    .comp_frac(comp[5:0]),
    .tick(tick)
  );
  ////////////////////////////////////////////////////////////////////////
  // BCD counting helpers.
  function automatic logic [3:0] bcd_inc(input logic [3:0] d);
    bcd_inc = (d == 4'h9) ? 4'h0 : d + 4'h1;
  endfunction
  wire sec_wrap = tick && tod[6:0] == 7'h59;
  wire min_wrap = sec_wrap && tod[14:8] == 7'h59;
  wire [5:0] hr = tod[21:16];
  wire hr_wrap24 = hr == 6'h23;
  // Twelve-hour sequence: 12 -> 01..11 -> 32 -> 21..31 -> 12.
  logic [5:0] next_hr;
  logic day_wrap;
  always_comb
  begin
    day_wrap = 1'b0;
    next_hr = {hr[5:4], bcd_inc(hr[3:0])};
    if (hr[3:0] == 4'h9)
      next_hr = {hr[5:4] + 2'h1, 4'h0};
    if (scale24)
    begin
      if (hr_wrap24)
      begin
        next_hr = 6'h00;
        day_wrap = 1'b1;
      end
    end
    else if (hr == 6'h12)
      next_hr = 6'h01;
    else if (hr == 6'h11)
      next_hr = {rtc_pm_offset[1:0] + 2'h1, 4'h2};
    else if (hr == 6'h32)
      next_hr = {rtc_pm_offset[1:0], 4'h1};
    else if (hr == 6'h31)
    begin
      next_hr = 6'h12;
      day_wrap = 1'b1;
    end
  end
  wire [7:0] day = cal[7:0];
  wire [7:0] mon = cal[15:8];
  wire [7:0] yr = cal[23:16];
  wire [7:0] days_in = (mon == 8'h02) ? ((yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
    : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8)) ? 8'h29 : 8'h28)
    : (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 || mon == 8'h11) ? 8'h30 : 8'h31;
  wire dwrap = min_wrap && tod[14:8] == 7'h59 && day_wrap;
  wire hr_step = min_wrap;
  wire mwrap = dwrap && day == days_in;
  wire ywrap = mwrap && mon == 8'h12;
  wire [7:0] nday = (day[3:0] == 4'h9) ? {day[7:4] + 4'h1, 4'h0} : {day[7:4], bcd_inc(day[3:0])};
  wire [7:0] nmon = (mon[3:0] == 4'h9) ? 8'h10 : {mon[7:4], bcd_inc(mon[3:0])};
  wire [7:0] nyr = (yr[3:0] == 4'h9) ? {bcd_inc(yr[7:4]), 4'h0} : {yr[7:4], bcd_inc(yr[3:0])};
  ////////////////////////////////////////////////////////////////////////
  // Time of day and calendar counters; software writes take priority.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      tod <= rtc_time_reset;
    else if (!active)
      tod <= rtc_time_reset;
    else if (wr_time)
      tod <= wb_dat_i & rtc_time_mask;
    else if (tick)
    begin
      tod[3:0] <= bcd_inc(tod[3:0]);
      if (tod[3:0] == 4'h9)
        tod[6:4] <= (tod[6:4] == 3'h5) ? 3'h0 : tod[6:4] + 3'h1;
      if (sec_wrap)
        tod[11:8] <= bcd_inc(tod[11:8]);
      if (sec_wrap && tod[11:8] == 4'h9)
        tod[14:12] <= (tod[14:12] == 3'h5) ? 3'h0 : tod[14:12] + 3'h1;
      if (hr_step)
        tod[21:16] <= next_hr;
    end
  end
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      cal <= rtc_cal_reset;
    else if (!active)
      cal <= rtc_cal_reset;
    else if (wr_cal)
      cal <= wb_dat_i & rtc_cal_mask;
    else if (dwrap)
    begin
      cal[7:0] <= mwrap ? 8'h01 : nday;
      if (mwrap)
        cal[15:8] <= ywrap ? 8'h01 : nmon;
      if (ywrap)
        cal[23:16] <= nyr;
    end
  end
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      comp <= rtc_comp_reset;
      scale24 <= 1'b1;
    end
    else if (!active)
    begin
      comp <= rtc_comp_reset;
      scale24 <= 1'b1;
    end
    else
    begin
      if (wr_comp)
        comp <= wb_dat_i & rtc_comp_mask;
      if (wr_scale)
        scale24 <= wb_dat_i[0];
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Read data; counters read only while access is open.
  logic [31:0] rdata;
  always_comb
  begin
    rdata = 32'h00000000;
    if (wb_adr_i == rtc_addr_init)
      rdata = {31'h00000000, active};
    else if (wb_adr_i == rtc_addr_access)
      rdata = 32'(access_ok) << rtc_access_bit;
    else if (gated && wb_adr_i == rtc_addr_comp)
      rdata = comp;
    else if (gated && wb_adr_i == rtc_addr_time)
      rdata = tod;
    else if (gated && wb_adr_i == rtc_addr_cal)
      rdata = cal;
    else if (gated && wb_adr_i == rtc_addr_scale)
      rdata = {31'h00000000, scale24};
  end
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wb_dat_o <= 32'h00000000;
      second_tick <= 1'b0;
    end
    else
    begin
      wb_dat_o <= req ? rdata : 32'h00000000;
      second_tick <= tick;
    end
  end
endmodule

// file: rtc_pkg.sv
// Package with register map, field layout and timing constants of the clock block.
package rtc_pkg;
  localparam int unsigned rtc_clk_hz = 50000000;
  localparam int unsigned rtc_nominal_hz = 32768;
  localparam logic [7:0] rtc_addr_init = 8'h00;
  localparam logic [7:0] rtc_addr_access = 8'h04;
  localparam logic [7:0] rtc_addr_comp = 8'h08;
  localparam logic [7:0] rtc_addr_time = 8'h0C;
  localparam logic [7:0] rtc_addr_cal = 8'h10;
  localparam logic [7:0] rtc_addr_scale = 8'h14;
  localparam logic [31:0] rtc_init_key = 32'hA5EB1357;
  localparam logic [15:0] rtc_access_key = 16'hA965;
  localparam logic [31:0] rtc_comp_reset = 32'h00000700;
  localparam logic [31:0] rtc_time_reset = 32'h00000000;
  localparam logic [31:0] rtc_cal_reset = 32'h00050101;
  localparam logic [31:0] rtc_comp_mask = 32'h00000F3F;
  localparam logic [31:0] rtc_time_mask = 32'h003F7F7F;
  localparam logic [31:0] rtc_cal_mask = 32'h00FF1F3F;
  localparam int unsigned rtc_access_bit = 16;
  // Seconds that the access flag stays set after the password write.
  localparam int unsigned rtc_access_hold_s = 1;
  // Integer code zero stands for 32761 Hz.
  localparam int unsigned rtc_int_base_hz = 32761;
  localparam int unsigned rtc_frac_steps = 60;
  localparam logic [3:0] rtc_pm_offset = 4'h2;
  typedef enum logic [2:0]
  {
    rtc_idle = 3'b001,
    rtc_ack = 3'b010,
    rtc_done = 3'b100
  } rtc_bus_t;
endpackage

// file: rtc_tick.sv
// Compensated one-second tick generator from the fast clock.
`timescale 1ns/100ps
module rtc_tick
  import rtc_pkg::*;
#(
  parameter int unsigned clk_hz = rtc_clk_hz
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic run,
  input wire logic [3:0] comp_int,
  input wire logic [5:0] comp_frac,
  output logic tick
);
  // A second ends when the cycles counted so far, times the measured rate in sixtieths
  // of a hertz, reach the fast clock rate times the nominal rate in sixtieths.
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  wire [31:0] osc_sixtieths = (32'(rtc_int_base_hz) + 32'(comp_int)) * 32'(rtc_frac_steps)
    + 32'(comp_frac);
  wire [63:0] limit = 64'(clk_hz) * 64'(rtc_nominal_hz) * 64'(rtc_frac_steps);
  assign next_cnt = cnt + 32'h00000001;
  wire [63:0] scaled = 64'(next_cnt) * 64'(osc_sixtieths);
  wire second_end = (scaled >= limit);
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt <= 32'h00000000;
      tick <= 1'b0;
    end
    else if (!run)
    begin
      cnt <= 32'h00000000;
      tick <= 1'b0;
    end
    else
    begin
      tick <= second_end;
      cnt <= second_end ? 32'h00000000 : next_cnt;
    end
  end
endmodule

// file: rtc_props.sv
// Checker of bus and tick timing at the clock block ports.
`timescale 1ns/100ps
module rtc_props
  import rtc_pkg::*;
#(
  parameter int unsigned clk_hz = rtc_clk_hz
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic second_tick
);
  logic init_seen;
  logic tick_seen;
  int gap;
  wire init_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == rtc_addr_init
    && wb_dat_i == rtc_init_key && wb_sel_i == 4'hF;
  // Tracks the initiation write and the cycles between ticks.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      init_seen <= 1'h0;
      tick_seen <= 1'h0;
      gap <= 0;
    end
    else
    begin
      init_seen <= init_seen || init_wr;
      tick_seen <= tick_seen || second_tick;
      gap <= second_tick ? 1 : gap + 1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_next_cycle: assert property ($rose(wb_stb_i) && wb_cyc_i |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
  a_locked_read_zero: assert property (
    wb_ack_o && !init_seen && wb_adr_i >= rtc_addr_comp |-> wb_dat_o == 32'h0)
    else $error("register readable before initiation");
  a_no_early_tick: assert property (!init_seen |-> !second_tick)
    else $error("tick before initiation");
  a_tick_pulse: assert property (second_tick |=> (!second_tick) [*8])
    else $error("tick not a single pulse");
  a_tick_period: assert property (second_tick && tick_seen |->
    gap >= clk_hz - clk_hz / 2000 - 2 && gap <= clk_hz + clk_hz / 2000 + 2)
    else $error("tick period out of range");
  c_tick: cover property (second_tick);
  c_write: cover property (wb_ack_o && wb_we_i);
  c_read: cover property (wb_ack_o && !wb_we_i && wb_dat_o != 32'h0);
endmodule
////////////////////////////////////////////////////////////////////////////////
bind rtc_core rtc_props #(.clk_hz(clk_hz)) u_props (.clk(clk), .nrst(nrst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .second_tick(second_tick));

// file: tb_rtc_core.sv
// Testbench of the clock block register file and tick.
`timescale 1ns/100ps
module tb_rtc_core;
  import rtc_pkg::*;
  localparam int unsigned hz = 8000;
  logic clk, nrst, cyc, stb, we, ack, tick;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat, rd, dat_o;
  int mismatches, tests_run, cycles, n;
  rtc_core #(.clk_hz(hz), .access_hold_cycles(100)) DUT (.clk(clk), .nrst(nrst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .second_tick(tick));
  initial
  begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (cycles == 90000)
    begin
      mismatches++;
      tally_and_finish;
    end
  end
  // One classic Wishbone cycle; read data lands in rd.
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    sel <= 4'hF;
    adr <= a;
    dat <= d;
    do @(posedge clk); while (ack !== 1'h1);
    rd = dat_o;
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    wb(1'h0, a, 32'h0);
    tests_run++;
    if ((rd & m) !== e)
    begin
      mismatches++;
      $display("CHECK FAILED reg %h exp %h got %h", a, e, rd & m);
    end
  endtask
  task unlock;
    wb(1'h1, rtc_addr_access, {16'h0000, rtc_access_key});
  endtask
  task sync;
    do @(posedge clk); while (tick !== 1'h1);
  endtask
  // Measures one tick period under integer code c and fraction code f.
  task period(input logic [3:0] c, input logic [5:0] f);
    real e;
    e = real'(hz) * real'(rtc_nominal_hz) * real'(rtc_frac_steps)
      / ((real'(rtc_int_base_hz) + real'(c)) * real'(rtc_frac_steps) + real'(f));
    unlock;
    wb(1'h1, rtc_addr_comp, {20'h00000, c, 2'h0, f});
    sync;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (tick !== 1'h1);
    tests_run++;
    if (real'(n) - e > 1.0 || e - real'(n) > 1.0)
    begin
      mismatches++;
      $display("CHECK FAILED tick period exp %0f got %0d", e, n);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    nrst = 1'h0;
    cyc = 1'h0;
    stb = 1'h0;
    we = 1'h0;
    adr = 8'h00;
    sel = 4'hF;
    dat = 32'h0;
    repeat (5) @(posedge clk);
    nrst <= 1'h1;
    rd_chk(rtc_addr_comp, 32'h0, 32'hFFFFFFFF);
    rd_chk(rtc_addr_init, 32'h0, 32'h1);
    unlock;
    rd_chk(rtc_addr_access, 32'h0, 32'h10000);
    wb(1'h1, rtc_addr_init, rtc_init_key);
    rd_chk(rtc_addr_init, 32'h1, 32'h1);
    $display("test initiation done");
    unlock;
    rd_chk(rtc_addr_access, 32'h10000, 32'h10000);
    rd_chk(rtc_addr_comp, 32'h00000700, 32'hFFFFFFFF);
    rd_chk(rtc_addr_time, 32'h0, 32'hFFFFFFFF);
    rd_chk(rtc_addr_cal, 32'h00050101, 32'hFFFFFFFF);
    rd_chk(rtc_addr_scale, 32'h1, 32'h1);
    rd_chk(8'h40, 32'h0, 32'hFFFFFFFF);
    wb(1'h1, rtc_addr_access, 32'h00001234);
    wb(1'h1, rtc_addr_comp, 32'h00000C27);
    rd_chk(rtc_addr_access, 32'h0, 32'h10000);
    unlock;
    rd_chk(rtc_addr_comp, 32'h00000700, 32'hFFFFFFFF);
    wb(1'h1, rtc_addr_comp, 32'hFFFFFC27);
    rd_chk(rtc_addr_comp, 32'h00000C27, 32'hFFFFFFFF);
    repeat (110) @(posedge clk);
    rd_chk(rtc_addr_access, 32'h0, 32'h10000);
    $display("test access gate done");
    sync;
    unlock;
    wb(1'h1, rtc_addr_time, 32'hFFFFFFFF);
    wb(1'h1, rtc_addr_cal, 32'hFFFFFFFF);
    rd_chk(rtc_addr_time, 32'h003F7F7F, 32'hFFFFFFFF);
    rd_chk(rtc_addr_cal, 32'h00FF1F3F, 32'hFFFFFFFF);
    $display("test unchecked load done");
    sync;
    unlock;
    wb(1'h1, rtc_addr_scale, 32'h0);
    wb(1'h1, rtc_addr_time, 32'h00115959);
    wb(1'h1, rtc_addr_cal, 32'h00991231);
    sync;
    unlock;
    rd_chk(rtc_addr_time, 32'h00320000, 32'hFFFFFFFF);
    wb(1'h1, rtc_addr_time, 32'h00315959);
    sync;
    unlock;
    rd_chk(rtc_addr_time, 32'h00120000, 32'hFFFFFFFF);
    rd_chk(rtc_addr_cal, 32'h00000101, 32'hFFFFFFFF);
    $display("test counting done");
    period(4'hF, 6'h3B);
    unlock;
    wb(1'h1, rtc_addr_scale, 32'h00000001);
    wb(1'h1, rtc_addr_time, 32'h00235959);
    wb(1'h1, rtc_addr_cal, 32'h00040228);
    period(4'h0, 6'h00);
    unlock;
    rd_chk(rtc_addr_time, 32'h00000001, 32'hFFFFFFFF);
    rd_chk(rtc_addr_cal, 32'h00040229, 32'hFFFFFFFF);
    $display("test compensation done");
    nrst <= 1'h0;
    repeat (2) @(posedge clk);
    nrst <= 1'h1;
    rd_chk(rtc_addr_init, 32'h0, 32'h1);
    wb(1'h1, rtc_addr_init, rtc_init_key);
    unlock;
    rd_chk(rtc_addr_cal, 32'h00050101, 32'hFFFFFFFF);
    $display("test second reset done");
    tally_and_finish;
  end
endmodule
